// File: design/tape_protection_sequencer.sv
// Purpose: Reel servo enable, servo relay and power-fail stop sequencing.
// Assumes: All inputs synchronous to clock; load_request is a pulse from the load button.
// Notes:   A power fail latches until power returns and a fresh load is made.
// Operation
// R1 - While reel enable is high the reel amplifiers run in normal tension mode.
// R2 - While reel enable is low the arm ramps drive both arms toward rest.
// R3 - The relay stays released at power-up and idle and closes when reel enable rises on load; a line loss in idle closes it for the hold.
// R4 - Three line periods without a line pulse start the power-fail sequence.
// R5 - Entering power fail asserts tape fault set, clearing all control flip-flops.
// R6 - During the power-fail stop all external commands are ignored.
// R7 - A 300 ms hold pulse keeps the relay energised so reels and capstan stop.
// R8 - During the hold all motion commands are forced off and reel enable is low.
// R9 - At the end of the hold the relay is released.
// R10 - A released relay connects the reel motors to the relaxer ramp path.
// R11 - An arm limit trip releases the relay, sets tape fault, goes off line and clears control.
// R12 - A load with a write ring fires the ring solenoid and lights the ring lamp.
// R13 - Without a sensed ring, write and erase power stay off.
// R14 - While broken tape fault is high control stays cleared, off line, reel enable low.
// R15 - Broken tape fault clears only by load with tape threaded, outside this block.
// R16 - Line loss is a tick counter restarted by each line pulse, flagged past three periods.
// R17 - Once started the power-fail sequence completes and stays latched until a new load.
`timescale 1ns/100ps
module tape_protection_sequencer
  import tape_protection_pkg::*;
#(
  parameter logic [COUNT_W-1:0] LOSS_LIMIT = LINE_LOSS_CYCLES[COUNT_W-1:0],
  parameter logic [COUNT_W-1:0] HOLD_LIMIT = HOLD_CYCLES[COUNT_W-1:0]
) (
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic line_pulse,
  input  wire logic broken_tape_fault,
  input  wire logic load_request,
  input  wire logic arm_limit_trip,
  input  wire logic write_ring_sensed,
  input  wire logic online_request,
  input  wire logic forward_cmd,
  input  wire logic reverse_cmd,
  input  wire logic write_request,
  output logic      reels_on,
  output logic      arm_rest_ramp,
  output logic      servo_relay,
  output logic      relaxer_connect,
  output logic      tape_fault_set,
  output logic      online,
  output logic      forward_out,
  output logic      reverse_out,
  output logic      ring_solenoid,
  output logic      ring_lamp,
  output logic      write_power,
  output logic      power_fail_active
);

  ////////////////////////////////////////////////////////////////////////////
  seq_state_t         state_q;
  seq_state_t         state_d;
  logic [COUNT_W-1:0] hold_q;
  logic [COUNT_W-1:0] hold_d;
  logic               line_lost;
  logic               relay_q;
  logic               reels_q;
  logic               online_q;
  logic               fwd_q;
  logic               rev_q;
  logic               ring_q;
  logic               wpow_q;
  logic               fault_set_q;

  line_loss_monitor #(
    .LIMIT      (LOSS_LIMIT)
  ) u_loss (
    .clock      (clock),
    .rst_b      (rst_b),
    .line_pulse (line_pulse),
    .line_lost  (line_lost)
  );

  ////////////////////////////////////////////////////////////////////////////
  wire hold_done   = (hold_q >= HOLD_LIMIT - COUNT_ONE);
  wire in_hold     = (state_q == ST_HOLD);
  wire in_relax    = (state_q == ST_RELAX);
  wire in_run      = (state_q == ST_RUN);
  // Loss has priority over a load so a dying line cannot restart the reels.
  wire fail_start  = line_lost && (state_q == ST_RUN || state_q == ST_FAULT); // R4
  wire trip_now    = arm_limit_trip && in_run; // R11
  wire load_ok     = load_request && !broken_tape_fault && !line_lost;
  wire cmds_live   = in_run && online_q && !broken_tape_fault; // R6 R14
  wire clear_ctl   = fault_set_q || broken_tape_fault || !in_run; // R5 R14
  wire write_ok    = cmds_live && write_request && write_ring_sensed; // R13

  always_comb begin
    state_d = state_q;
    hold_d  = COUNT_ZERO;
    case (state_q)
      ST_FAULT: begin
        if (fail_start) state_d = ST_HOLD;
        else if (load_ok) state_d = ST_RUN;
      end
      ST_RUN: begin
        if (fail_start) state_d = ST_HOLD; // R4
        else if (trip_now || broken_tape_fault) state_d = ST_FAULT; // R11 R14
      end
      ST_HOLD: begin
        hold_d = hold_q + COUNT_ONE; // R7
        if (hold_done) state_d = ST_RELAX; // R9 R17
      end
      ST_RELAX: begin
        if (!line_lost && load_ok) state_d = ST_RUN; // R17
      end
      default: state_d = ST_FAULT;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q     <= ST_FAULT;
      hold_q      <= COUNT_ZERO;
      fault_set_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      hold_q      <= hold_d;
      fault_set_q <= fail_start || trip_now || (state_d == ST_HOLD); // R5 R11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Relay follows reel enable in normal use and is held on only by the hold pulse.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      relay_q  <= 1'b0;
      reels_q  <= 1'b0;
      online_q <= 1'b0;
      fwd_q    <= 1'b0;
      rev_q    <= 1'b0;
      ring_q   <= 1'b0;
      wpow_q   <= 1'b0;
    end else begin
      relay_q  <= (state_d == ST_RUN) || (state_d == ST_HOLD); // R3 R7 R9 R11
      reels_q  <= (state_d == ST_RUN) && !broken_tape_fault; // R1 R8 R14
      online_q <= (state_d == ST_RUN) && !clear_ctl && online_request; // R11 R14
      fwd_q    <= cmds_live && (state_d == ST_RUN) && forward_cmd; // R6 R8
      rev_q    <= cmds_live && (state_d == ST_RUN) && reverse_cmd; // R6 R8
      ring_q   <= (state_d == ST_RUN) && write_ring_sensed && (ring_q || load_ok); // R12
      // Gated by the next state too, so a trip or line loss drops write power on the same edge.
      wpow_q   <= write_ok && ring_q && (state_d == ST_RUN); // R5 R13
    end
  end

  assign reels_on          = reels_q;
  assign arm_rest_ramp     = !reels_q; // R2
  assign servo_relay       = relay_q;
  assign relaxer_connect   = !relay_q; // R10
  assign tape_fault_set    = fault_set_q;
  assign online            = online_q;
  assign forward_out       = fwd_q;
  assign reverse_out       = rev_q;
  assign ring_solenoid     = ring_q;
  assign ring_lamp         = ring_q;
  assign write_power       = wpow_q;
  assign power_fail_active = in_hold || in_relax;

  ////////////////////////////////////////////////////////////////////////////
  property p_hold_relay;
    @(posedge clock) disable iff (!rst_b) in_hold |-> servo_relay;
  endproperty
  a_hold_relay: assert property (p_hold_relay) else $error("relay dropped in hold"); // R7

  property p_hold_quiet;
    @(posedge clock) disable iff (!rst_b)
      in_hold |-> !reels_on && !forward_out && !reverse_out && !online && !write_power;
  endproperty
  a_hold_quiet: assert property (p_hold_quiet) else $error("motion during hold"); // R8

  property p_fail_fault;
    @(posedge clock) disable iff (!rst_b) fail_start |=> tape_fault_set && in_hold;
  endproperty
  a_fail_fault: assert property (p_fail_fault) else $error("no fault on fail"); // R5

  property p_hold_end;
    @(posedge clock) disable iff (!rst_b) in_hold && hold_done |=> !servo_relay;
  endproperty
  a_hold_end: assert property (p_hold_end) else $error("relay held after pulse"); // R9

  property p_relax_path;
    @(posedge clock) disable iff (!rst_b) relaxer_connect != servo_relay;
  endproperty
  a_relax_path: assert property (p_relax_path) else $error("relaxer path wrong"); // R10

  property p_trip;
    @(posedge clock) disable iff (!rst_b)
      trip_now && !fail_start |=> tape_fault_set && !servo_relay && !online;
  endproperty
  a_trip: assert property (p_trip) else $error("trip not handled"); // R11

  property p_ring;
    @(posedge clock) disable iff (!rst_b) !write_ring_sensed |=> !write_power && !ring_lamp;
  endproperty
  a_ring: assert property (p_ring) else $error("write power without ring"); // R13

  property p_bt;
    @(posedge clock) disable iff (!rst_b) broken_tape_fault |=> !reels_on && !online;
  endproperty
  a_bt: assert property (p_bt) else $error("active with broken tape"); // R14

  property p_latch;
    @(posedge clock) disable iff (!rst_b) in_relax && !load_request |=> in_relax;
  endproperty
  a_latch: assert property (p_latch) else $error("power fail unlatched"); // R17

  c_load: cover property (@(posedge clock) disable iff (!rst_b) load_ok ##1 in_run);
  c_fail: cover property (@(posedge clock) disable iff (!rst_b) in_hold ##1 in_relax);
  c_trip: cover property (@(posedge clock) disable iff (!rst_b) trip_now);
  c_ring: cover property (@(posedge clock) disable iff (!rst_b) ring_lamp);

endmodule : tape_protection_sequencer

// File: design/tape_protection_pkg.sv
// Purpose: Shared constants and state type for the tape protection sequencer.
// Assumes: System clock of 250 MHz; line cycle pulse arrives once per AC period.
// Notes:   Long counts are also top-level parameters so a simulation can shorten them.
package tape_protection_pkg;

  localparam int unsigned CLOCK_MHZ         = 250;
  localparam int unsigned LINE_PERIOD_US    = 16667;
  localparam int unsigned LINE_LOSS_PERIODS = 3;
  localparam int unsigned HOLD_MS           = 300;

  // Least times round up; the hold is a longest time and rounds down.
  localparam int unsigned LINE_LOSS_CYCLES  = LINE_LOSS_PERIODS * LINE_PERIOD_US * CLOCK_MHZ;
  localparam int unsigned HOLD_CYCLES       = HOLD_MS * 1000 * CLOCK_MHZ;

  localparam int unsigned COUNT_W           = 28;
  localparam logic [COUNT_W-1:0] COUNT_ZERO = 28'h0000000;
  localparam logic [COUNT_W-1:0] COUNT_ONE  = 28'h0000001;

  typedef enum logic [2:0] {
    ST_FAULT,
    ST_RUN,
    ST_HOLD,
    ST_RELAX
  } seq_state_t;

endpackage : tape_protection_pkg

// File: design/line_loss_monitor.sv
// Purpose: Detects loss of AC line cycles by counting ticks since the last line pulse.
// Assumes: line_pulse is a one-cycle pulse per line period, synchronous to clock.
// Notes:   The counter saturates so a long outage keeps the flag high.
`timescale 1ns/100ps
module line_loss_monitor
  import tape_protection_pkg::*;
#(
  parameter logic [COUNT_W-1:0] LIMIT = LINE_LOSS_CYCLES[COUNT_W-1:0]
) (
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic line_pulse,
  output logic      line_lost
);

  logic [COUNT_W-1:0] count_q;
  logic [COUNT_W-1:0] count_d;
  logic               lost_q;
  wire                at_limit = (count_q >= LIMIT);

  assign count_d   = line_pulse ? COUNT_ZERO : (at_limit ? count_q : count_q + COUNT_ONE); // R16
  assign line_lost = lost_q;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= COUNT_ZERO;
      lost_q  <= 1'b0;
    end else begin
      count_q <= count_d;
      lost_q  <= at_limit && !line_pulse; // R4 R16
    end
  end

  property p_loss_after_limit;
    @(posedge clock) disable iff (!rst_b)
      (count_q == LIMIT - COUNT_ONE) && !line_pulse ##1 !line_pulse |=> line_lost;
  endproperty
  a_loss_after_limit: assert property (p_loss_after_limit) else $error("no loss flag"); // R16

  property p_pulse_clears;
    @(posedge clock) disable iff (!rst_b) line_pulse |=> !line_lost;
  endproperty
  a_pulse_clears: assert property (p_pulse_clears) else $error("loss flag after pulse"); // R4

endmodule : line_loss_monitor

// File: tb/tape_deck_model.sv
// Purpose: Far side of the sequencer: AC line monitor pulses and broken tape sensing.
// Assumes: Line period of 8 ticks, shorter than the shortened loss limit.
// Notes:   Line pulses stop dead while power is off.
`timescale 1ns/100ps
module tape_deck_model (
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic power_on,
  input  wire logic tape_threaded,
  input  wire logic load_request,
  output logic      line_pulse,
  output logic      broken_tape_fault
);
  logic [2:0] tick_q;
  assign line_pulse = power_on && (tick_q == 3'h7);
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tick_q            <= 3'h0;
      broken_tape_fault <= 1'b1;
    end else begin
      tick_q <= power_on ? tick_q + 3'h1 : 3'h0;
      if (!tape_threaded) begin
        broken_tape_fault <= 1'b1;
      end else if (load_request) begin
        broken_tape_fault <= 1'b0;
      end
    end
  end
endmodule : tape_deck_model

// File: tb/tb.sv
// Purpose: Self-checking bench for the tape protection sequencer.
// Assumes: Loss limit 20 and hold limit 50 ticks.
// Notes:   A load is pressed twice, since the first press only clears the tape fault.
`timescale 1ns/100ps
module tb;
  import tape_protection_pkg::*;
  logic clock, rst_b, line_pulse, broken_tape_fault, load_request, arm_limit_trip;
  logic write_ring_sensed, online_request, forward_cmd, reverse_cmd, write_request;
  logic reels_on, arm_rest_ramp, servo_relay, relaxer_connect, tape_fault_set, online;
  logic forward_out, reverse_out, ring_solenoid, ring_lamp, write_power, power_fail_active;
  logic power_on, tape_threaded;
  int   error_cnt, comparisons;
  localparam logic [27:0] HOLD_SIM = 28'h0000032;
  localparam int          CLOCK_NS = 4;
  tape_protection_sequencer #(.LOSS_LIMIT(28'h0000014), .HOLD_LIMIT(HOLD_SIM)) dut (
    .clock(clock), .rst_b(rst_b), .line_pulse(line_pulse),
    .broken_tape_fault(broken_tape_fault), .load_request(load_request),
    .arm_limit_trip(arm_limit_trip), .write_ring_sensed(write_ring_sensed),
    .online_request(online_request), .forward_cmd(forward_cmd), .reverse_cmd(reverse_cmd),
    .write_request(write_request), .reels_on(reels_on), .arm_rest_ramp(arm_rest_ramp),
    .servo_relay(servo_relay), .relaxer_connect(relaxer_connect),
    .tape_fault_set(tape_fault_set), .online(online), .forward_out(forward_out),
    .reverse_out(reverse_out), .ring_solenoid(ring_solenoid), .ring_lamp(ring_lamp),
    .write_power(write_power), .power_fail_active(power_fail_active));
  tape_deck_model deck (.clock(clock), .rst_b(rst_b), .power_on(power_on),
    .tape_threaded(tape_threaded), .load_request(load_request), .line_pulse(line_pulse),
    .broken_tape_fault(broken_tape_fault));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic press_load();
    repeat (2) begin
      @(negedge clock) load_request = 1'b1;
      @(negedge clock) load_request = 1'b0;
      repeat (2) @(negedge clock);
    end
  endtask : press_load
  task automatic t_load_ring();
    write_ring_sensed = 1'b1;
    press_load();
    chk(reels_on, 1'b1);
    chk(arm_rest_ramp, 1'b0);
    chk(servo_relay, 1'b1);
    chk(relaxer_connect, 1'b0);
    chk(ring_solenoid, 1'b1);
    chk(ring_lamp, 1'b1);
    online_request = 1'b1;
    forward_cmd    = 1'b1;
    write_request  = 1'b1;
    repeat (3) @(negedge clock);
    chk(online, 1'b1);
    chk(forward_out, 1'b1);
    chk(write_power, 1'b1);
    forward_cmd = 1'b0;
    reverse_cmd = 1'b1;
    repeat (2) @(negedge clock);
    chk(reverse_out, 1'b1);
    chk(forward_out, 1'b0);
    forward_cmd = 1'b1;
  endtask : t_load_ring
  task automatic t_broken();
    tape_threaded = 1'b0;
    repeat (3) @(negedge clock);
    press_load();
    chk(reels_on, 1'b0);
    chk(online, 1'b0);
    chk(forward_out, 1'b0);
    chk(reverse_out, 1'b0);
    chk(write_power, 1'b0);
    tape_threaded = 1'b1;
    press_load();
    chk(reels_on, 1'b1);
  endtask : t_broken
  task automatic t_trip();
    @(negedge clock) arm_limit_trip = 1'b1;
    @(negedge clock);
    chk(tape_fault_set, 1'b1);
    chk(servo_relay, 1'b0);
    chk(online, 1'b0);
    chk(relaxer_connect, 1'b1);
    chk(forward_out, 1'b0);
    chk(write_power, 1'b0);
    arm_limit_trip = 1'b0;
    press_load();
    chk(servo_relay, 1'b1);
    chk(reels_on, 1'b1);
  endtask : t_trip
  task automatic t_power_fail();
    int  n;
    time t_fail;
    n = 0;
    repeat (40) @(negedge clock);
    chk(power_fail_active, 1'b0);
    power_on = 1'b0;
    while (tape_fault_set !== 1'b1 && n < 40) begin
      @(negedge clock);
      n++;
    end
    chk(n >= 12 && n <= 24, 1'b1);
    t_fail = $time;
    chk(servo_relay, 1'b1);
    chk(reels_on, 1'b0);
    chk(forward_out, 1'b0);
    chk(reverse_out, 1'b0);
    chk(write_power, 1'b0);
    chk(online, 1'b0);
    press_load();
    chk(online, 1'b0);
    while (servo_relay === 1'b1 && n < 120) begin
      @(negedge clock);
      n++;
    end
    // The relay must hold for exactly the hold pulse, counted from the first fault cycle.
    chk(($time - t_fail) == HOLD_SIM * CLOCK_NS, 1'b1);
    chk(relaxer_connect, 1'b1);
    chk(power_fail_active, 1'b1);
    power_on = 1'b1;
    repeat (20) @(negedge clock);
    chk(power_fail_active, 1'b1);
    chk(servo_relay, 1'b0);
    press_load();
    chk(power_fail_active, 1'b0);
    chk(servo_relay, 1'b1);
  endtask : t_power_fail
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial begin
    #40000;
    error_cnt++;
    summarize();
  end
  initial begin
    {load_request, arm_limit_trip, write_ring_sensed, online_request} = 4'h0;
    {forward_cmd, reverse_cmd, write_request} = 3'h0;
    {power_on, tape_threaded} = 2'h3;
    error_cnt   = 0;
    comparisons = 0;
    rst_b       = 1'b0;
    repeat (4) @(posedge clock);
    @(negedge clock) rst_b = 1'b1;
    chk(servo_relay, 1'b0);
    chk(arm_rest_ramp, 1'b1);
    chk(relaxer_connect, 1'b1);
    t_load_ring();
    t_broken();
    t_trip();
    t_power_fail();
    // A load without a ring must leave write and erase unpowered.
    write_ring_sensed = 1'b0;
    tape_threaded     = 1'b0;
    @(negedge clock) tape_threaded = 1'b1;
    press_load();
    repeat (3) @(negedge clock);
    chk(ring_solenoid, 1'b0);
    chk(write_power, 1'b0);
    summarize();
  end
endmodule : tb
